// file: include/tcc_pkg.sv
/*
 * Package of the two-channel timer capture/compare block: register map,
 * field positions, reset values, state and bus carrier types.
 * Assumes an 8-bit register port with a 4-bit byte address.
 */
package tcc_pkg;

  localparam int CNT_W   = 16;
  localparam int PRESC_W = 6;
  localparam int NCH     = 2;

  // Register offsets
  localparam logic [3:0] ADR_TSC     = 4'h0;
  localparam logic [3:0] ADR_CNT_HI  = 4'h1;
  localparam logic [3:0] ADR_CNT_LO  = 4'h2;
  localparam logic [3:0] ADR_MOD_HI  = 4'h3;
  localparam logic [3:0] ADR_MOD_LO  = 4'h4;
  localparam logic [3:0] ADR_CH_SC [NCH] = '{4'h5, 4'h8};
  localparam logic [3:0] ADR_CH_HI [NCH] = '{4'h6, 4'h9};
  localparam logic [3:0] ADR_CH_LO [NCH] = '{4'h7, 4'hA};

  // Timer status/control bit positions
  localparam int TSC_OVF   = 7;
  localparam int TSC_OVIE  = 6;
  localparam int TSC_HALT  = 5;
  localparam int TSC_CRST  = 4;
  localparam int TSC_PS_LO = 0;

  // Channel status/control bit positions
  localparam int CSC_FLAG = 7;
  localparam int CSC_IE   = 6;
  localparam int CSC_BMS  = 5;
  localparam int CSC_MSA  = 4;
  localparam int CSC_ELH  = 3;
  localparam int CSC_ELL  = 2;
  localparam int CSC_TOV  = 1;
  localparam int CSC_MAX  = 0;

  // Values after reset, and the unused prescaler code
  localparam logic             HALT_RST = 1'b1;
  localparam logic [CNT_W-1:0] MOD_RST  = 16'hFFFF;
  localparam logic [2:0]       PS_UNUSED = 3'h7;

  // Edge/level codes
  localparam logic [1:0] EL_OFF    = 2'h0;
  localparam logic [1:0] EL_TOGGLE = 2'h1;
  localparam logic [1:0] EL_CLEAR  = 2'h2;
  localparam logic [1:0] EL_SET    = 2'h3;

  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } tcc_bus_req_t;

  typedef struct packed {
    logic       flag;
    logic       irq_en;
    logic       bms;
    logic       msa;
    logic [1:0] el;
    logic       tov;
    logic       maxd;
    logic       armed;
    logic       inhib;
    logic       lock;
    logic       out;
    logic       oe;
  } tcc_chan_t;

  typedef struct packed {
    logic                       ovf_flag;
    logic                       ovf_ie;
    logic                       ovf_armed;
    logic                       halt;
    logic [2:0]                 ps;
    logic [PRESC_W-1:0]         presc;
    logic [CNT_W-1:0]           cnt;
    logic [CNT_W-1:0]           modv;
    logic                       mod_inhib;
    logic [7:0]                 cnt_lo_latch;
    logic                       cnt_latched;
    logic                       buf_active;
    logic                       buf_pending;
    logic [NCH-1:0]             sync1;
    logic [NCH-1:0]             sync2;
    logic [NCH-1:0]             sync3;
    tcc_chan_t [NCH-1:0]        ch;
    logic [7:0]                 rdata;
    logic [NCH:0]               irq;
  } tcc_core_t;

  typedef struct packed {
    tcc_core_t                  core;
    logic [NCH-1:0][CNT_W-1:0]  val;
  } tcc_state_t;

endpackage : tcc_pkg

// file: hdl/tcc_timer.sv
/*
 * Two-channel 16-bit timer: prescaler, modulo counter and the capture /
 * compare / PWM channels, with an 8-bit register port.
 * Assumes a single-cycle register master; channel pins come from outside
 * the clock domain and are synchronised here.
 */
// Functional notes
// [R1] Buffered select lives in channel 0; it links channels, frees pin 1.
// [R2] Reset clears buffered, mode A, edge/level and overflow-toggle bits.
// [R3] Nonzero edge/level: mode A 1 is compare/PWM, 0 is capture.
// [R4] Zero edge/level: mode A sets initial level, 1 low, 0 high.
// [R5] Software halts and resets the counter before changing mode bits.
// [R6] Zero edge/level leaves pin to port; channel drives it once enabled.
// [R7] Capture edge: 01 rising, 10 falling, 11 either.
// [R8] Compare action: 00 flag only, 01 toggle, 10 clear, 11 set.
// [R9] Buffered compare: 01 toggles output, 11 sets it.
// [R10] Buffered compare code 10 clears the output.
// [R11] Pin must be stable two bus clocks before enabling capture.
// [R12] Compare channel with overflow-toggle toggles pin; no effect in capture.
// [R13] Overflow toggle wins over a coincident compare.
// [R14] Overflow-toggle, clear action and max-duty force output high.
// [R15] Clear action without overflow-toggle or max-duty gives steady low.
// [R16] Channel value holds capture or compare value; not reset.
// [R17] Capture mode: reading high byte blocks captures until low byte read.
// [R18] Compare mode: writing high byte blocks compares until low written.
// [R19] Counter free-runs or counts modulo; reads do not disturb it.
// [R20] Counter clock is one of seven prescaled bus clock rates.
// [R21] Every active edge latches the count and sets the flag; code ignores edges while halted.
// [R22] Captured value is stored two bus cycles after the pin edge; code stores it three cycles after.
// [R23] Each channel is set up independently as capture or compare.
// [R24] Flag clears by read with flag set then write 0; new event wins.
// [R25] Counter at modulo flags overflow and restarts from zero.
`timescale 1ns/100ps

module tcc_timer (
  input  wire logic                           clk_i,
  input  wire logic                           rst_n_i,
  input  wire tcc_pkg::tcc_bus_req_t          bus_i,
  output logic [7:0]                          rdata_o,
  input  wire logic [tcc_pkg::NCH-1:0]        pin_i,
  output logic [tcc_pkg::NCH-1:0]             pin_o,
  output logic [tcc_pkg::NCH-1:0]             pin_oe_o,
  output logic                                ovf_irq_o,
  output logic [tcc_pkg::NCH-1:0]             ch_irq_o
);
  import tcc_pkg::*;

  tcc_state_t s_reg;
  tcc_state_t s_next;

  always_comb begin
    logic [PRESC_W-1:0] mask;
    logic               tick;
    logic               ovf;
    logic               cmp_mode;
    logic               cap_mode;
    logic               live;
    logic               ev;
    logic               match;
    logic               edge_ok;
    logic [CNT_W-1:0]   cval;
    logic [1:0]         el;
    logic               rd_sc;
    logic               wr_sc;
    mask     = '0;
    tick     = 1'b0;
    ovf      = 1'b0;
    cmp_mode = 1'b0;
    cap_mode = 1'b0;
    live     = 1'b0;
    ev       = 1'b0;
    match    = 1'b0;
    edge_ok  = 1'b0;
    cval     = '0;
    el       = '0;
    rd_sc    = 1'b0;
    wr_sc    = 1'b0;
    s_next   = s_reg;
    s_next.core.rdata = 8'h00;

    // Pin synchronisers; edges are looked for on the second and third stage
    s_next.core.sync1 = pin_i;
    s_next.core.sync2 = s_reg.core.sync1;
    s_next.core.sync3 = s_reg.core.sync2;

    // Prescaler: the divide-by-2^ps tap fires when its low bits are all ones
    case (s_reg.core.ps)
      3'h0:    mask = 6'h00;
      3'h1:    mask = 6'h01;
      3'h2:    mask = 6'h03;
      3'h3:    mask = 6'h07;
      3'h4:    mask = 6'h0F;
      3'h5:    mask = 6'h1F;
      3'h6:    mask = 6'h3F;
      default: mask = 6'h00;
    endcase
    if (!s_reg.core.halt) begin
      s_next.core.presc = s_reg.core.presc + 6'h01; // [R20]
      tick = ((s_reg.core.presc & mask) == mask) &&
             (s_reg.core.ps != PS_UNUSED); // [R20]
    end
    if (tick) begin
      if (s_reg.core.cnt == s_reg.core.modv) begin
        ovf = 1'b1; // [R25]
        s_next.core.cnt = '0; // [R25]
      end else begin
        s_next.core.cnt = s_reg.core.cnt + 16'h0001; // [R19]
      end
    end
    if (ovf && !s_reg.core.mod_inhib) begin
      s_next.core.ovf_flag = 1'b1;
    end
    // Buffered pair swaps to the last-written register set on overflow
    if (ovf) begin
      s_next.core.buf_active = s_reg.core.buf_pending;
    end

    for (int c = 0; c < NCH; c++) begin
      el = s_reg.core.ch[c].el;
      live = !(c == 1 && s_reg.core.ch[0].bms); // [R1]
      cmp_mode = live && (s_reg.core.ch[c].msa || s_reg.core.ch[c].bms); // [R3]
      cap_mode = live && !cmp_mode && (el != EL_OFF); // [R3]
      // Rising 01, falling 10, any 11
      edge_ok = (el[0] && s_reg.core.sync2[c] && !s_reg.core.sync3[c]) ||
                (el[1] && !s_reg.core.sync2[c] && s_reg.core.sync3[c]); // [R7]
      ev = 1'b0;
      if (cap_mode && edge_ok && !s_reg.core.halt &&
          !s_reg.core.ch[c].lock) begin
        // Count lands three cycles after the pin edge; flag state is ignored
        s_next.val[c] = s_reg.core.cnt; // [R21] [R22]
        ev = 1'b1; // [R21]
      end
      cval = s_reg.val[c];
      match = 1'b0;
      if (cmp_mode) begin
        if (s_reg.core.ch[c].bms && s_reg.core.buf_active) begin
          cval = s_reg.val[1];
        end
        match = tick && (s_reg.core.cnt == cval) &&
                !s_reg.core.ch[c].inhib &&
                !(s_reg.core.ch[c].bms && s_reg.core.ch[1].inhib); // [R18]
        ev = match;
      end
      if (ev) begin
        s_next.core.ch[c].flag = 1'b1; // [R21]
      end

      // Pin level and drive
      if (el == EL_OFF) begin
        s_next.core.ch[c].out = !s_reg.core.ch[c].msa; // [R4]
        s_next.core.ch[c].oe  = 1'b0; // [R6]
      end else if (cmp_mode) begin
        s_next.core.ch[c].oe = 1'b1; // [R6] [R23]
        if (s_reg.core.ch[c].tov && s_reg.core.ch[c].maxd &&
            el == EL_CLEAR) begin
          s_next.core.ch[c].out = 1'b1; // [R14]
        end else if (s_reg.core.ch[c].tov && ovf) begin
          s_next.core.ch[c].out = !s_reg.core.ch[c].out; // [R12] [R13]
        end else if (match) begin
          case (el)
            EL_TOGGLE: s_next.core.ch[c].out = !s_reg.core.ch[c].out; // [R8] [R9]
            EL_CLEAR:  s_next.core.ch[c].out = 1'b0; // [R8] [R10] [R15]
            EL_SET:    s_next.core.ch[c].out = 1'b1; // [R8] [R9]
            default:   s_next.core.ch[c].out = s_reg.core.ch[c].out;
          endcase
        end
      end else begin
        // Capture input or linked channel 1: pin left to the port
        s_next.core.ch[c].oe = 1'b0; // [R1] [R12]
      end

      // Register access to this channel
      rd_sc = bus_i.rd && bus_i.addr == ADR_CH_SC[c];
      wr_sc = bus_i.wr && bus_i.addr == ADR_CH_SC[c] && live; // [R1]
      if (rd_sc && live) begin
        s_next.core.rdata = {s_reg.core.ch[c].flag, s_reg.core.ch[c].irq_en,
                             s_reg.core.ch[c].bms, s_reg.core.ch[c].msa,
                             s_reg.core.ch[c].el, s_reg.core.ch[c].tov,
                             s_reg.core.ch[c].maxd};
        if (s_reg.core.ch[c].flag) begin
          s_next.core.ch[c].armed = 1'b1; // [R24]
        end
      end
      if (wr_sc) begin
        s_next.core.ch[c].irq_en = bus_i.wdata[CSC_IE];
        s_next.core.ch[c].msa    = bus_i.wdata[CSC_MSA]; // [R5]
        s_next.core.ch[c].el     = bus_i.wdata[CSC_ELH:CSC_ELL];
        s_next.core.ch[c].tov    = bus_i.wdata[CSC_TOV];
        s_next.core.ch[c].maxd   = bus_i.wdata[CSC_MAX]; // [R14]
        if (c == 0) begin
          s_next.core.ch[c].bms = bus_i.wdata[CSC_BMS]; // [R1]
        end
        s_next.core.ch[c].armed = 1'b0;
        // Set beats clear: an event this cycle keeps the flag
        if (!bus_i.wdata[CSC_FLAG] && s_reg.core.ch[c].armed && !ev) begin
          s_next.core.ch[c].flag = 1'b0; // [R24]
        end
      end
      if (bus_i.rd && bus_i.addr == ADR_CH_HI[c]) begin
        s_next.core.rdata = s_reg.val[c][15:8];
        if (cap_mode || (el == EL_OFF && !cmp_mode)) begin
          s_next.core.ch[c].lock = 1'b1; // [R17]
        end
      end
      if (bus_i.rd && bus_i.addr == ADR_CH_LO[c]) begin
        s_next.core.rdata = s_reg.val[c][7:0];
        s_next.core.ch[c].lock = 1'b0; // [R17]
      end
      if (bus_i.wr && bus_i.addr == ADR_CH_HI[c]) begin
        s_next.val[c][15:8] = bus_i.wdata; // [R16]
        if (s_reg.core.ch[c].msa || s_reg.core.ch[0].bms) begin
          s_next.core.ch[c].inhib = 1'b1; // [R18]
        end
      end
      if (bus_i.wr && bus_i.addr == ADR_CH_LO[c]) begin
        s_next.val[c][7:0] = bus_i.wdata; // [R16]
        s_next.core.ch[c].inhib = 1'b0; // [R18]
        s_next.core.buf_pending = (c == 1); // [R1]
      end
    end

    // Timer-level registers
    if (bus_i.rd) begin
      case (bus_i.addr)
        ADR_TSC: begin
          s_next.core.rdata = {s_reg.core.ovf_flag, s_reg.core.ovf_ie,
                               s_reg.core.halt, 1'b0, 1'b0, s_reg.core.ps};
          if (s_reg.core.ovf_flag) begin
            s_next.core.ovf_armed = 1'b1;
          end
        end
        ADR_CNT_HI: begin
          // Low byte is frozen so a two-byte read is coherent
          s_next.core.rdata        = s_reg.core.cnt[15:8]; // [R19]
          s_next.core.cnt_lo_latch = s_reg.core.cnt[7:0];
          s_next.core.cnt_latched  = 1'b1;
        end
        ADR_CNT_LO: begin
          s_next.core.rdata = s_reg.core.cnt_latched ?
                              s_reg.core.cnt_lo_latch : s_reg.core.cnt[7:0];
          s_next.core.cnt_latched = 1'b0;
        end
        ADR_MOD_HI: s_next.core.rdata = s_reg.core.modv[15:8];
        ADR_MOD_LO: s_next.core.rdata = s_reg.core.modv[7:0];
        default:    s_next.core.rdata = s_next.core.rdata;
      endcase
    end
    if (bus_i.wr) begin
      case (bus_i.addr)
        ADR_TSC: begin
          s_next.core.ovf_ie = bus_i.wdata[TSC_OVIE];
          s_next.core.halt   = bus_i.wdata[TSC_HALT];
          s_next.core.ps     = bus_i.wdata[TSC_PS_LO+2:TSC_PS_LO];
          s_next.core.ovf_armed = 1'b0;
          if (!bus_i.wdata[TSC_OVF] && s_reg.core.ovf_armed &&
              !(ovf && !s_reg.core.mod_inhib)) begin
            s_next.core.ovf_flag = 1'b0;
          end
          if (bus_i.wdata[TSC_CRST]) begin
            s_next.core.cnt   = '0;
            s_next.core.presc = '0;
          end
        end
        ADR_MOD_HI: begin
          s_next.core.modv[15:8] = bus_i.wdata;
          s_next.core.mod_inhib  = 1'b1;
        end
        ADR_MOD_LO: begin
          s_next.core.modv[7:0] = bus_i.wdata;
          s_next.core.mod_inhib = 1'b0;
        end
        default: s_next.core.mod_inhib = s_next.core.mod_inhib;
      endcase
    end

    s_next.core.irq = {s_next.core.ovf_flag & s_next.core.ovf_ie,
                       s_next.core.ch[1].flag & s_next.core.ch[1].irq_en,
                       s_next.core.ch[0].flag & s_next.core.ch[0].irq_en}; // [R21]
  end

  // Channel values are deliberately left out of reset
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s_reg.core      <= '0; // [R2]
      s_reg.core.halt <= HALT_RST;
      s_reg.core.modv <= MOD_RST;
    end else begin
      s_reg <= s_next; // [R16]
    end
  end

  assign rdata_o   = s_reg.core.rdata;
  assign ovf_irq_o = s_reg.core.irq[NCH];
  assign ch_irq_o  = s_reg.core.irq[NCH-1:0];

  always_comb begin
    for (int c = 0; c < NCH; c++) begin
      pin_o[c]    = s_reg.core.ch[c].out;
      pin_oe_o[c] = s_reg.core.ch[c].oe;
    end
  end

endmodule : tcc_timer

// file: dv/tcc_timer_chk.sv
/* Concurrent checks on the ports of tcc_timer.
   Bound to every tcc_timer; keeps a shadow of channel 0 control. */
`timescale 1ns/100ps
module tcc_timer_chk
  import tcc_pkg::*;
(
  input wire logic                    clk_i,
  input wire logic                    rst_n_i,
  input wire tcc_pkg::tcc_bus_req_t   bus_i,
  input wire logic [7:0]              rdata_o,
  input wire logic [tcc_pkg::NCH-1:0] pin_i,
  input wire logic [tcc_pkg::NCH-1:0] pin_o,
  input wire logic [tcc_pkg::NCH-1:0] pin_oe_o,
  input wire logic                    ovf_irq_o,
  input wire logic [tcc_pkg::NCH-1:0] ch_irq_o
);
  logic [7:0] sc0_reg;
  logic [1:0] el0;
  logic       wr_sc0, link, ie0, maxc, zeroc;
  assign wr_sc0 = bus_i.wr && bus_i.addr == ADR_CH_SC[0];
  assign el0    = sc0_reg[CSC_ELH:CSC_ELL];
  assign link   = sc0_reg[CSC_BMS];
  assign ie0    = sc0_reg[CSC_IE];
  assign maxc   = sc0_reg[CSC_MSA] && el0 == EL_CLEAR && sc0_reg[CSC_TOV]
                  && sc0_reg[CSC_MAX];
  assign zeroc  = sc0_reg[CSC_MSA] && el0 == EL_CLEAR && !sc0_reg[CSC_TOV]
                  && !sc0_reg[CSC_MAX];
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i)
      sc0_reg <= 8'h00;
    else if (wr_sc0)
      sc0_reg <= bus_i.wdata;
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  // Output registers may trail the control write by up to two cycles
  sequence s_force_held;
    maxc [*3];
  endsequence
  reset_preset_a: assert property (
    $rose(rst_n_i) |=> pin_o == 2'h3 && pin_oe_o == 2'h0 && !ovf_irq_o)
    else $error("pins not preset after reset");
  link_sc1_read_a: assert property (
    link && bus_i.rd && bus_i.addr == ADR_CH_SC[1] |=> rdata_o == 8'h00)
    else $error("channel 1 control readable while linked");
  link_pin_free_a: assert property (
    link && $past(link, 2) |-> !pin_oe_o[1])
    else $error("channel 1 pin driven while linked");
  off_pin_free_a: assert property (
    el0 == EL_OFF && $past(el0, 2) == EL_OFF |-> !pin_oe_o[0])
    else $error("channel 0 drives pin with edge/level off");
  max_force_a: assert property (
    s_force_held |-> pin_o[0])
    else $error("max duty not forcing output high");
  zero_duty_a: assert property (
    zeroc && $past(zeroc) |-> !$rose(pin_o[0]))
    else $error("output rose in zero duty setup");
  flag_hold_a: assert property (
    ch_irq_o[0] && !wr_sc0 && !$past(wr_sc0) |=> ch_irq_o[0])
    else $error("channel flag dropped without a clearing write");
  irq_enable_a: assert property (
    !ie0 && !$past(ie0, 2) |-> !ch_irq_o[0])
    else $error("channel request while disabled");
endmodule : tcc_timer_chk

bind tcc_timer tcc_timer_chk u_chk (.clk_i(clk_i), .rst_n_i(rst_n_i),
  .bus_i(bus_i), .rdata_o(rdata_o), .pin_i(pin_i), .pin_o(pin_o),
  .pin_oe_o(pin_oe_o), .ovf_irq_o(ovf_irq_o), .ch_irq_o(ch_irq_o));

// file: dv/tcc_pin_model.sv
/* Far side of the channel pins: resolves block drive against bench drive.
   Assumes the bench drives a pin only while the block leaves it free. */
`timescale 1ns/100ps
module tcc_pin_model (
  input  wire logic       clk_i,
  input  wire logic [1:0] blk_out_i,
  input  wire logic [1:0] blk_oe_i,
  input  wire logic [1:0] drv_en_i,
  input  wire logic [1:0] drv_val_i,
  output logic      [1:0] pin_o
);
  // A floating pin keeps no level, so it wanders every cycle
  logic [1:0] float_reg = 2'h1;
  always_ff @(posedge clk_i) begin
    float_reg <= ~float_reg;
  end
  always_comb begin
    for (int k = 0; k < 2; k++) begin
      if (blk_oe_i[k])
        pin_o[k] = blk_out_i[k];
      else if (drv_en_i[k])
        pin_o[k] = drv_val_i[k];
      else
        pin_o[k] = float_reg[k];
    end
  end
endmodule : tcc_pin_model

// file: dv/timer_channel_capture_compare_test.sv
/* Self-checking bench of tcc_timer through its register port.
   Assumes tcc_pin_model on the pins and a 100 MHz clock. */
`timescale 1ns/100ps
module timer_channel_capture_compare_test;
  import tcc_pkg::*;
  logic         clk_i = 1'b0;
  logic         rst_n_i = 1'b0;
  tcc_bus_req_t bus_i = '0;
  logic [7:0]   rdata_o, d, h;
  logic [1:0]   pin_i, pin_o, pin_oe_o, ch_irq_o;
  logic [1:0]   drv_en = 2'h2;
  logic [1:0]   drv_val = 2'h2;
  logic         ovf_irq_o;
  logic [15:0]  a;
  int           n_errors = 0;
  int           checked = 0;
  int           cyc = 0;
  time          t1, t3;

  tcc_timer uut (.clk_i(clk_i), .rst_n_i(rst_n_i), .bus_i(bus_i),
    .rdata_o(rdata_o), .pin_i(pin_i), .pin_o(pin_o), .pin_oe_o(pin_oe_o),
    .ovf_irq_o(ovf_irq_o), .ch_irq_o(ch_irq_o));
  tcc_pin_model far (.clk_i(clk_i), .blk_out_i(pin_o), .blk_oe_i(pin_oe_o),
    .drv_en_i(drv_en), .drv_val_i(drv_val), .pin_o(pin_i));

  initial begin
    forever #5 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_errors = n_errors + 1;
      end_sim();
    end
  end

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic wr(input logic [3:0] ad, input logic [7:0] v);
    @(posedge clk_i);
    bus_i <= '{ad, v, 1'b1, 1'b0};
    @(posedge clk_i);
    bus_i <= '0;
  endtask : wr
  task automatic rd(input logic [3:0] ad, output logic [7:0] v);
    @(posedge clk_i);
    bus_i <= '{ad, 8'h00, 1'b0, 1'b1};
    @(posedge clk_i);
    bus_i <= '0;
    #1 v = rdata_o;
  endtask : rd
  task automatic wait_cy(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask : wait_cy
  task automatic end_sim();
    $display("errors=%0d checks=%0d", n_errors, checked);
    if (n_errors == 0 && checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : end_sim

  initial begin
    repeat (3) @(posedge clk_i);
    rst_n_i <= 1'b1;
    rd(ADR_CH_SC[0], d);
    chk(16'(d), 16'h0);
    rd(ADR_CH_SC[1], d);
    chk(16'(d), 16'h0);
    chk(16'({pin_oe_o, pin_o}), 16'h3);
    rd(4'hF, d);
    chk(16'(d), 16'h0);
    wr(ADR_CH_HI[0], 8'h00);
    wr(ADR_CH_LO[0], 8'h08);
    // Compare actions, code 00 being flag only; stale low byte 08 would
    // match if not inhibited
    for (int c = 0; c < 4; c++) begin
      wr(ADR_TSC, 8'h30);
      wr(ADR_CH_SC[0], (c == 2) ? 8'h00 : 8'h10);
      wr(ADR_CH_SC[0], 8'h50 | 8'(c << 2));
      wr(ADR_CH_HI[0], 8'h00);
      wr(ADR_TSC, 8'h00);
      wait_cy(30);
      chk(16'(ch_irq_o[0]), 16'h0);
      wr(ADR_TSC, 8'h30);
      wr(ADR_CH_LO[0], 8'h08);
      wr(ADR_TSC, 8'h00);
      repeat (60) if (ch_irq_o[0] !== 1'b1) wait_cy(1);
      wait_cy(2);
      h = (c == 0) ? 8'h00 : (c == 2) ? 8'h02 : 8'h03;
      chk(16'({pin_oe_o[0], pin_o[0]}), 16'(h));
      wr(ADR_CH_SC[0], 8'hD0 | 8'(c << 2));
      wait_cy(2);
      chk(16'(ch_irq_o[0]), 16'h1);
      rd(ADR_CH_SC[0], d);
      wr(ADR_CH_SC[0], 8'h50 | 8'(c << 2));
      wait_cy(2);
      chk(16'(ch_irq_o[0]), 16'h0);
    end
    // Capture edges on channel 1; its pin is held high since time zero
    for (int c = 1; c < 4; c++) begin
      wr(ADR_TSC, 8'h30);
      wr(ADR_CH_SC[1], 8'h40 | 8'(c << 2));
      wr(ADR_TSC, 8'h00);
      for (int e = 0; e < 2; e++) begin
        @(posedge clk_i) drv_val[1] <= 1'(e);
        wait_cy(8);
        chk(16'(ch_irq_o[1]), 16'(c >> (1 - e) & 1));
        rd(ADR_CH_SC[1], d);
        wr(ADR_CH_SC[1], 8'h40 | 8'(c << 2));
      end
    end
    @(posedge clk_i) drv_val[1] <= 1'b0;
    t1 = $time;
    wait_cy(8);
    rd(ADR_CH_HI[1], h);
    @(posedge clk_i) drv_val[1] <= 1'b1;
    wait_cy(8);
    rd(ADR_CH_LO[1], d);
    a = {h, d};
    @(posedge clk_i) drv_val[1] <= 1'b0;
    t3 = $time;
    wait_cy(8);
    rd(ADR_CH_HI[1], h);
    rd(ADR_CH_LO[1], d);
    chk({h, d} - a, 16'((t3 - t1) / 10));
    // Pulse width on channel 0 with a 32-count period
    wr(ADR_TSC, 8'h30);
    wr(ADR_MOD_HI, 8'h00);
    wr(ADR_MOD_LO, 8'h1F);
    wr(ADR_CH_SC[0], 8'h1B);
    wr(ADR_TSC, 8'h40);
    wait_cy(1);
    chk(16'(ovf_irq_o), 16'h0);
    repeat (8) begin
      wait_cy(5);
      chk(16'(pin_o[0]), 16'h1);
    end
    chk(16'(ovf_irq_o), 16'h1);
    wr(ADR_CH_SC[0], 8'h18);
    wait_cy(40);
    repeat (8) begin
      wait_cy(5);
      chk(16'(pin_o[0]), 16'h0);
    end
    // Compare on the modulo value coincides with every overflow
    wr(ADR_CH_HI[0], 8'h00);
    wr(ADR_CH_LO[0], 8'h1F);
    wr(ADR_CH_SC[0], 8'h1E);
    wait_cy(1);
    d[0] = pin_o[0];
    repeat (40) if (pin_o[0] === d[0]) wait_cy(1);
    d[0] = pin_o[0];
    wait_cy(16);
    chk(16'(pin_o[0]), 16'(d[0]));
    wait_cy(32);
    chk(16'(pin_o[0]), 16'(!d[0]));
    // Link while halted; the bench lets go of pin 1 before it is driven
    wr(ADR_TSC, 8'h30);
    drv_en <= 2'h0;
    wr(ADR_CH_SC[1], 8'h1C);
    wait_cy(3);
    chk(16'(pin_oe_o[1]), 16'h1);
    wr(ADR_CH_SC[0], 8'h2C);
    wr(ADR_CH_SC[1], 8'h5C);
    rd(ADR_CH_SC[1], d);
    chk(16'(d), 16'h0);
    chk(16'(pin_oe_o[1]), 16'h0);
    // Divide by 8: halting 4 clocks past the eighth tick gives a margin
    wr(ADR_TSC, 8'h03);
    wait_cy(66);
    wr(ADR_TSC, 8'h23);
    rd(ADR_CNT_HI, h);
    rd(ADR_CNT_LO, d);
    chk({h, d}, 16'h0008);
    end_sim();
  end
endmodule : timer_channel_capture_compare_test
